// File: core/clct_pkg.sv
// Constants and types shared by the camera link capture and trigger block
package clct_pkg;
   // ==========================================================
   // Clocks and rates
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned PIX_CLK_MAX_HZ = 85_000_000;
   localparam int unsigned REF_CLK_HZ = 50_000_000;
   localparam int unsigned REF_HALF_RAW = CLK_HZ / (2 * REF_CLK_HZ);
   localparam int unsigned REF_HALF_CYC = (REF_HALF_RAW < 1) ? 1 : REF_HALF_RAW;
   localparam int unsigned REF_CNT_W = 8;

   // ==========================================================
   // Pixel path
   localparam int unsigned BASE_PIX_W = 24;
   localparam int unsigned MED_PIX_W = 48;
   localparam int unsigned FULL_PIX_W = 64;
   localparam int unsigned FIFO_DEPTH = 16;

   // ==========================================================
   // Camera control select bits
   localparam int unsigned CC_N = 4;
   localparam int unsigned CC1_SEL_BIT = 0;
   localparam int unsigned CC2_SEL_BIT = 1;
   localparam int unsigned CC3_SEL_BIT = 2;
   localparam int unsigned CC4_SEL_BIT = 3;

   // ==========================================================
   // Trigger, encoder, serial link
   localparam int unsigned TRIG_N = 2;
   localparam int unsigned TRIG_CNT_W = 16;
   localparam int unsigned ENC_CNT_W = 32;
   localparam int unsigned UART_DATA_BITS = 8;
   localparam int unsigned UART_FRAME_BITS = 10;
   localparam int unsigned UART_CNT_W = 4;
   localparam int unsigned BAUD_DIV_W = 16;
   localparam int unsigned BAUD_9600 = 9600;
   localparam int unsigned BAUD_19200 = 19200;
   localparam int unsigned BAUD_38400 = 38400;
   localparam int unsigned BAUD_57600 = 57600;
   localparam int unsigned BAUD_115200 = 115200;
   localparam int unsigned BAUD_DIV_9600 = (CLK_HZ + BAUD_9600 / 2) / BAUD_9600;
   localparam int unsigned BAUD_DIV_19200 = (CLK_HZ + BAUD_19200 / 2) / BAUD_19200;
   localparam int unsigned BAUD_DIV_38400 = (CLK_HZ + BAUD_38400 / 2) / BAUD_38400;
   localparam int unsigned BAUD_DIV_57600 = (CLK_HZ + BAUD_57600 / 2) / BAUD_57600;
   localparam int unsigned BAUD_DIV_115200 = (CLK_HZ + BAUD_115200 / 2) / BAUD_115200;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {CLCT_CFG_BASE, CLCT_CFG_MEDIUM, CLCT_CFG_FULL} clct_cfg_t;
   typedef enum logic [2:0] {
      CLCT_BAUD_9600, CLCT_BAUD_19200, CLCT_BAUD_38400, CLCT_BAUD_57600, CLCT_BAUD_115200
   } clct_baud_t;
   typedef enum logic [1:0] {CLCT_TRG_IDLE, CLCT_TRG_DELAY, CLCT_TRG_HIGH, CLCT_TRG_BLANK}
      clct_trg_st_t;
   typedef struct packed {
      logic fval;
      logic lval;
      logic dval;
      logic spare;
      logic [FULL_PIX_W-1:0] data;
   } clct_pix_t;
   typedef struct packed {
      logic spare;
      logic [FULL_PIX_W-1:0] data;
   } clct_word_t;
   typedef struct packed {
      logic [TRIG_CNT_W-1:0] delay;
      logic [TRIG_CNT_W-1:0] width;
      logic [TRIG_CNT_W-1:0] blank;
   } clct_trig_cfg_t;
   typedef struct packed {
      logic a;
      logic b;
      logic z;
   } clct_enc_t;
endpackage

// File: core/clct_top.sv
// Camera link pixel capture, camera control, trigger, encoder and serial logic
`timescale 1ns/1ps

// ==========================================================
// Word FIFO
module clct_fifo #(
   parameter int unsigned W = 8,
   parameter int unsigned DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int unsigned AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0] wr;
      logic [AW:0] rd;
      logic out_vld;
      logic [W-1:0] out_dat;
   } clct_fifo_st_t;
   clct_fifo_st_t s, next_s;
   logic full, empty;

   assign full = (s.wr[AW] != s.rd[AW]) && (s.wr[AW-1:0] == s.rd[AW-1:0]);
   assign empty = (s.wr == s.rd);
   assign in_ready_o = !full;
   assign out_valid_o = s.out_vld;
   assign out_data_o = s.out_dat;

   always_comb begin
      next_s = s;
      if (in_valid_i && !full) begin
         next_s.mem[s.wr[AW-1:0]] = in_data_i;
         next_s.wr = s.wr + 1'b1;
      end
      if (out_ready_i && !empty) begin
         next_s.rd = s.rd + 1'b1;
      end
      // Head kept in flops so the top's word outputs need no read mux
      next_s.out_vld = (next_s.wr != next_s.rd);
      next_s.out_dat = next_s.mem[next_s.rd[AW-1:0]];
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

// ==========================================================
// Programmable trigger pulse generator
module clct_trig (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic start_i,
   input wire clct_pkg::clct_trig_cfg_t cfg_i,
   output logic pulse_o
);
   import clct_pkg::*;
   typedef struct packed {
      clct_trg_st_t st;
      logic [TRIG_CNT_W-1:0] cnt;
      logic pulse;
   } clct_trig_st_t;
   clct_trig_st_t s, next_s;
   logic [TRIG_CNT_W-1:0] w1;

   assign pulse_o = s.pulse;

   always_comb begin
      next_s = s;
      // Zero width still gives one cycle of pulse
      w1 = (cfg_i.width == '0) ? '0 : cfg_i.width - 1'b1;
      unique case (s.st)
         CLCT_TRG_IDLE: begin
            if (start_i) begin
               if (cfg_i.delay == '0) begin
                  next_s.st = CLCT_TRG_HIGH;
                  next_s.cnt = w1;
               end else begin
                  next_s.st = CLCT_TRG_DELAY;
                  next_s.cnt = cfg_i.delay - 1'b1;
               end
            end
         end
         CLCT_TRG_DELAY: begin
            if (s.cnt == '0) begin
               next_s.st = CLCT_TRG_HIGH;
               next_s.cnt = w1;
            end else begin
               next_s.cnt = s.cnt - 1'b1;
            end
         end
         CLCT_TRG_HIGH: begin
            if (s.cnt != '0) begin
               next_s.cnt = s.cnt - 1'b1;
            end else if (cfg_i.blank == '0) begin
               next_s.st = CLCT_TRG_IDLE;
            end else begin
               next_s.st = CLCT_TRG_BLANK;
               next_s.cnt = cfg_i.blank - 1'b1;
            end
         end
         CLCT_TRG_BLANK: begin
            // Starts are ignored until the blank interval runs out
            if (s.cnt == '0) begin
               next_s.st = CLCT_TRG_IDLE;
            end else begin
               next_s.cnt = s.cnt - 1'b1;
            end
         end
      endcase
      next_s.pulse = (next_s.st == CLCT_TRG_HIGH);
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

// ==========================================================
// Top
module clct_top #(
   parameter int unsigned DIV_9600 = clct_pkg::BAUD_DIV_9600
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic pix_clk_i,
   input wire clct_pkg::clct_pix_t pix_i,
   input wire clct_pkg::clct_cfg_t cfg_mode_i,
   output clct_pkg::clct_word_t word_o,
   output logic word_valid_o,
   input wire logic word_ready_i,
   output logic overflow_o,
   input wire logic overflow_clr_i,
   input wire logic [clct_pkg::CC_N-1:0] cc_sel_i,
   input wire logic [clct_pkg::CC_N-1:0] dig_out_i,
   output logic [clct_pkg::CC_N-1:0] cc_o,
   input wire logic [clct_pkg::TRIG_N-1:0] trig_start_i,
   input wire logic [clct_pkg::TRIG_N-1:0] trig_on_index_i,
   input wire clct_pkg::clct_trig_cfg_t first_trig_cfg_i,
   input wire clct_pkg::clct_trig_cfg_t second_trig_cfg_i,
   input wire logic ext_trig_i,
   input wire clct_pkg::clct_enc_t enc_i,
   output logic enc_dir_o,
   output logic [clct_pkg::ENC_CNT_W-1:0] enc_count_o,
   output logic enc_index_o,
   input wire clct_pkg::clct_baud_t baud_sel_i,
   input wire logic [clct_pkg::UART_DATA_BITS-1:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   output logic ser_tx_o,
   input wire logic ser_rx_i,
   output logic [clct_pkg::UART_DATA_BITS-1:0] rx_data_o,
   output logic rx_valid_o,
   output logic rx_frame_err_o
);
   import clct_pkg::*;
   typedef struct packed {
      logic pclk_m;
      logic pclk_s;
      logic pclk_d;
      clct_pix_t pix_m;
      clct_pix_t pix_s;
      clct_enc_t enc_m;
      clct_enc_t enc_s;
      clct_enc_t enc_d;
      logic ext_m;
      logic ext_s;
      logic rx_m;
      logic rx_s;
      logic ovf;
      logic [CC_N-1:0] cc;
      logic ref_clk;
      logic [REF_CNT_W-1:0] ref_cnt;
      logic enc_dir;
      logic [ENC_CNT_W-1:0] enc_cnt;
      logic enc_idx;
      logic tx_busy;
      logic tx_rdy;
      logic ser_tx;
      logic [UART_FRAME_BITS-1:0] tx_sh;
      logic [UART_CNT_W-1:0] tx_left;
      logic [BAUD_DIV_W-1:0] tx_div;
      logic rx_busy;
      logic rx_valid;
      logic rx_ferr;
      logic [UART_CNT_W-1:0] rx_left;
      logic [BAUD_DIV_W-1:0] rx_div;
      logic [UART_DATA_BITS-1:0] rx_sh;
      logic [UART_DATA_BITS-1:0] rx_data;
   } clct_state_t;
   clct_state_t s, next_s;

   logic pix_edge, push, fifo_in_ready, z_rise;
   logic [FULL_PIX_W-1:0] mask;
   int unsigned pix_w;
   clct_word_t fifo_in;
   logic [TRIG_N-1:0] trig_go;
   logic [TRIG_N-1:0] trig_pulse;
   logic [BAUD_DIV_W-1:0] div;

   // ==========================================================
   // Pixel capture
   always_comb begin
      unique case (cfg_mode_i)
         CLCT_CFG_BASE: pix_w = BASE_PIX_W;
         CLCT_CFG_MEDIUM: pix_w = MED_PIX_W;
         CLCT_CFG_FULL: pix_w = FULL_PIX_W;
         default: pix_w = FULL_PIX_W;
      endcase
   end
   // Lanes of wider configurations are forced to zero so stale cables never leak in
   assign mask = {FULL_PIX_W{1'b1}} >> (FULL_PIX_W - pix_w);
   // Pixel clock is only sampled; words faster than half of clk_i are lost
   assign pix_edge = s.pclk_s && !s.pclk_d;
   assign push = pix_edge && s.pix_s.fval && s.pix_s.lval && s.pix_s.dval;
   assign fifo_in.spare = s.pix_s.spare;
   assign fifo_in.data = s.pix_s.data & mask;

   clct_fifo #(
      .W($bits(clct_word_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(push),
      .in_ready_o(fifo_in_ready),
      .in_data_i(fifo_in),
      .out_valid_o(word_valid_o),
      .out_ready_i(word_ready_i),
      .out_data_o(word_o)
   );

   // ==========================================================
   // Triggers
   assign z_rise = s.enc_s.z && !s.enc_d.z;
   assign trig_go = trig_start_i | (trig_on_index_i & {TRIG_N{z_rise}});

   clct_trig u_first_trig (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .start_i(trig_go[0]),
      .cfg_i(first_trig_cfg_i),
      .pulse_o(trig_pulse[0])
   );

   clct_trig u_second_trig (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .start_i(trig_go[1]),
      .cfg_i(second_trig_cfg_i),
      .pulse_o(trig_pulse[1])
   );

   // ==========================================================
   // Serial rate
   always_comb begin
      unique case (baud_sel_i)
         CLCT_BAUD_9600: div = BAUD_DIV_W'(DIV_9600);
         CLCT_BAUD_19200: div = BAUD_DIV_W'(BAUD_DIV_19200);
         CLCT_BAUD_38400: div = BAUD_DIV_W'(BAUD_DIV_38400);
         CLCT_BAUD_57600: div = BAUD_DIV_W'(BAUD_DIV_57600);
         default: div = BAUD_DIV_W'(BAUD_DIV_115200);
      endcase
   end

   // ==========================================================
   // Next state
   always_comb begin
      next_s = s;
      next_s.pclk_m = pix_clk_i;
      next_s.pclk_s = s.pclk_m;
      next_s.pclk_d = s.pclk_s;
      next_s.pix_m = pix_i;
      next_s.pix_s = s.pix_m;
      next_s.enc_m = enc_i;
      next_s.enc_s = s.enc_m;
      next_s.enc_d = s.enc_s;
      next_s.ext_m = ext_trig_i;
      next_s.ext_s = s.ext_m;
      next_s.rx_m = ser_rx_i;
      next_s.rx_s = s.rx_m;

      // Set wins over a clear in the same cycle
      next_s.ovf = (s.ovf && !overflow_clr_i) || (push && !fifo_in_ready);

      if (s.ref_cnt == REF_CNT_W'(REF_HALF_CYC - 1)) begin
         next_s.ref_cnt = '0;
         next_s.ref_clk = !s.ref_clk;
      end else begin
         next_s.ref_cnt = s.ref_cnt + 1'b1;
      end
      next_s.cc[CC1_SEL_BIT] = cc_sel_i[CC1_SEL_BIT] ? trig_pulse[0]
                                                    : dig_out_i[CC1_SEL_BIT];
      next_s.cc[CC2_SEL_BIT] = cc_sel_i[CC2_SEL_BIT] ? trig_pulse[1]
                                                    : dig_out_i[CC2_SEL_BIT];
      next_s.cc[CC3_SEL_BIT] = cc_sel_i[CC3_SEL_BIT] ? s.ext_s
                                                    : dig_out_i[CC3_SEL_BIT];
      next_s.cc[CC4_SEL_BIT] = cc_sel_i[CC4_SEL_BIT] ? s.ref_clk
                                                    : dig_out_i[CC4_SEL_BIT];

      // Both phases changing at once is a glitch and is not counted
      next_s.enc_idx = z_rise;
      if ((s.enc_s.a ^ s.enc_d.a) != (s.enc_s.b ^ s.enc_d.b)) begin
         next_s.enc_dir = s.enc_s.a ^ s.enc_d.b;
         next_s.enc_cnt = next_s.enc_dir ? s.enc_cnt + 1'b1 : s.enc_cnt - 1'b1;
      end

      // Transmitter; rate change mid-frame takes effect at the next bit
      if (!s.tx_busy) begin
         next_s.ser_tx = 1'b1;
         if (tx_valid_i) begin
            next_s.tx_busy = 1'b1;
            next_s.tx_sh = {1'b1, tx_data_i, 1'b0};
            next_s.tx_left = UART_CNT_W'(UART_FRAME_BITS - 1);
            next_s.tx_div = div - 1'b1;
            next_s.ser_tx = 1'b0;
         end
      end else if (s.tx_div != '0) begin
         next_s.tx_div = s.tx_div - 1'b1;
      end else if (s.tx_left == '0) begin
         next_s.tx_busy = 1'b0;
         next_s.ser_tx = 1'b1;
      end else begin
         next_s.tx_sh = {1'b1, s.tx_sh[UART_FRAME_BITS-1:1]};
         next_s.ser_tx = s.tx_sh[1];
         next_s.tx_left = s.tx_left - 1'b1;
         next_s.tx_div = div - 1'b1;
      end
      next_s.tx_rdy = !next_s.tx_busy;

      // Receiver samples mid-bit
      next_s.rx_valid = 1'b0;
      next_s.rx_ferr = 1'b0;
      if (!s.rx_busy) begin
         if (!s.rx_s) begin
            next_s.rx_busy = 1'b1;
            next_s.rx_div = div >> 1;
            next_s.rx_left = UART_CNT_W'(UART_FRAME_BITS - 1);
         end
      end else if (s.rx_div != '0) begin
         next_s.rx_div = s.rx_div - 1'b1;
      end else begin
         next_s.rx_div = div - 1'b1;
         if (s.rx_left == UART_CNT_W'(UART_FRAME_BITS - 1)) begin
            // A start bit gone high at mid-bit was noise
            next_s.rx_busy = !s.rx_s;
            next_s.rx_left = s.rx_left - 1'b1;
         end else if (s.rx_left == '0) begin
            next_s.rx_busy = 1'b0;
            next_s.rx_data = s.rx_s ? s.rx_sh : s.rx_data;
            next_s.rx_valid = s.rx_s;
            next_s.rx_ferr = !s.rx_s;
         end else begin
            next_s.rx_sh = {s.rx_s, s.rx_sh[UART_DATA_BITS-1:1]};
            next_s.rx_left = s.rx_left - 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         s <= '0;
         s.ser_tx <= 1'b1;
         s.tx_rdy <= 1'b1;
         s.rx_m <= 1'b1;
         s.rx_s <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign overflow_o = s.ovf;
   assign cc_o = s.cc;
   assign enc_dir_o = s.enc_dir;
   assign enc_count_o = s.enc_cnt;
   assign enc_index_o = s.enc_idx;
   assign tx_ready_o = s.tx_rdy;
   assign ser_tx_o = s.ser_tx;
   assign rx_data_o = s.rx_data;
   assign rx_valid_o = s.rx_valid;
   assign rx_frame_err_o = s.rx_ferr;
endmodule

// File: tb/clct_top_asserts.sv
// Concurrent checks on the ports of the capture and trigger block
`timescale 1ns/1ps
module clct_top_asserts #(
   parameter int unsigned DIV_9600 = clct_pkg::BAUD_DIV_9600
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire clct_pkg::clct_pix_t pix_i,
   input wire clct_pkg::clct_cfg_t cfg_mode_i,
   input wire clct_pkg::clct_word_t word_o,
   input wire logic word_valid_o,
   input wire logic overflow_o,
   input wire logic overflow_clr_i,
   input wire logic [clct_pkg::CC_N-1:0] cc_sel_i,
   input wire logic [clct_pkg::CC_N-1:0] dig_out_i,
   input wire logic [clct_pkg::CC_N-1:0] cc_o,
   input wire logic ext_trig_i,
   input wire clct_pkg::clct_enc_t enc_i,
   input wire logic enc_dir_o,
   input wire logic [clct_pkg::ENC_CNT_W-1:0] enc_count_o,
   input wire logic enc_index_o,
   input wire logic tx_valid_i,
   input wire logic tx_ready_o,
   input wire logic ser_tx_o
);
   import clct_pkg::*;
   logic [3:0] up;
   // ==========================================================
   // Cycles since reset; synchronisers need refilling after each reset
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         up <= 4'h0;
      end else if (up != 4'hf) begin
         up <= up + 4'h1;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // ==========================================================
   // Camera control lines
   a_cc1_digital: assert property (!cc_sel_i[0] |=> cc_o[0] == $past(dig_out_i[0]))
      else $error("line 1 does not follow its digital output");
   a_cc2_digital: assert property (!cc_sel_i[1] |=> cc_o[1] == $past(dig_out_i[1]))
      else $error("line 2 does not follow its digital output");
   a_cc3_external: assert property (
      up > 4'h4 ##2 cc_sel_i[2] |=> cc_o[2] == $past(ext_trig_i, 3))
      else $error("line 3 does not carry the external trigger");
   a_cc4_refclk: assert property (
      up > 4'h2 && cc_sel_i[3] && $past(cc_sel_i[3]) |=> cc_o[3] != $past(cc_o[3]))
      else $error("line 4 reference clock stalled");
   // ==========================================================
   // Encoder
   a_enc_step: assert property (
      up > 4'h4 && enc_i.a != $past(enc_i.a) && enc_i.b == $past(enc_i.b)
      |-> ##[2:4] enc_count_o != $past(enc_count_o))
      else $error("encoder phase step not counted");
   a_enc_dir_count: assert property (
      up > 4'h4 && enc_count_o != $past(enc_count_o)
      |-> enc_count_o - $past(enc_count_o) == (enc_dir_o ? 32'h1 : 32'hffffffff))
      else $error("count step disagrees with direction");
   a_index_pulse: assert property (
      up > 4'h4 && enc_i.z && !$past(enc_i.z) |-> ##[2:3] enc_index_o ##1 !enc_index_o)
      else $error("index pulse missing or too long");
   // ==========================================================
   // Pixel store and serial link
   a_pix_qualified: assert property (
      $rose(word_valid_o) && up == 4'hf |-> $past(pix_i.fval && pix_i.lval && pix_i.dval, 2))
      else $error("word stored without all qualifiers");
   a_base_width: assert property (
      word_valid_o && cfg_mode_i == CLCT_CFG_BASE |-> word_o.data[63:24] == 40'h0)
      else $error("base word wider than 24 bits");
   a_ovf_sticky: assert property (overflow_o && !overflow_clr_i |=> overflow_o)
      else $error("overflow flag dropped without clear");
   a_tx_start: assert property (tx_valid_i && tx_ready_o |=> !ser_tx_o && !tx_ready_o)
      else $error("serial start bit not sent");
endmodule

bind clct_top clct_top_asserts #(.DIV_9600(DIV_9600)) u_asserts (.clk_i, .sys_rst_i, .pix_i,
   .cfg_mode_i, .word_o, .word_valid_o, .overflow_o, .overflow_clr_i, .cc_sel_i, .dig_out_i,
   .cc_o, .ext_trig_i, .enc_i, .enc_dir_o, .enc_count_o, .enc_index_o, .tx_valid_i,
   .tx_ready_o, .ser_tx_o);

// File: tb/clct_cam_model.sv
// Behavioural camera driving the pixel clock and pixel word
`timescale 1ns/1ps
module clct_cam_model #(
   parameter int unsigned HALF_NS = 80
) (
   output logic pix_clk_o,
   output clct_pkg::clct_pix_t pix_o
);
   import clct_pkg::*;
   initial begin
      pix_clk_o = 1'b0;
      pix_o = '0;
   end
   // ==========================================================
   // One word per call; the clock stands still between calls
   task automatic send(input clct_pix_t w);
      #7 pix_o = w;
      #HALF_NS pix_clk_o = 1'b1;
      #HALF_NS pix_clk_o = 1'b0;
      // Stale bits flipped and qualifiers dropped, never a held copy
      pix_o = {3'b000, ~w.spare, ~w.data};
   endtask
endmodule

// File: tb/tb.sv
// Self-checking bench for the camera link capture and trigger block
`timescale 1ns/1ps
module tb;
   import clct_pkg::*;
   localparam int unsigned DIV = 16;
   typedef struct packed {logic [3:0] sel; logic [3:0] dig; logic ext; logic [3:0] exp;}
      clct_row_t;
   localparam clct_row_t ROWS [6] = '{'{4'h0, 4'h5, 1'b0, 4'h5}, '{4'h0, 4'ha, 1'b1, 4'ha},
      '{4'h4, 4'h0, 1'b1, 4'h4}, '{4'h4, 4'hb, 1'b0, 4'hb}, '{4'h3, 4'hf, 1'b1, 4'hc},
      '{4'h7, 4'hf, 1'b1, 4'hc}};
   localparam logic [1:0] SEQ [8] = '{2'b10, 2'b11, 2'b01, 2'b00, 2'b01, 2'b11, 2'b10, 2'b00};
   localparam logic [63:0] MASK [3] = '{64'hffffff, 64'hffffffffffff, 64'hffffffffffffffff};
   localparam logic [63:0] PAT = 64'hfedcba9876543210;
   localparam int unsigned DV [5] = '{DIV, BAUD_DIV_19200, BAUD_DIV_38400, BAUD_DIV_57600,
      BAUD_DIV_115200};
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic pix_clk_i;
   clct_pix_t pix_i;
   clct_cfg_t cfg_mode_i = CLCT_CFG_FULL;
   clct_word_t word_o;
   logic word_ready_i = 1'b0;
   logic overflow_clr_i = 1'b0;
   logic [3:0] cc_sel_i = 4'h0;
   logic [3:0] dig_out_i = 4'h0;
   logic [1:0] trig_start_i = 2'h0;
   logic [1:0] trig_on_index_i = 2'h0;
   clct_trig_cfg_t first_trig_cfg_i = {16'h2, 16'h3, 16'h8};
   clct_trig_cfg_t second_trig_cfg_i = '0;
   logic ext_trig_i = 1'b0;
   clct_enc_t enc_i = '0;
   clct_baud_t baud_sel_i = CLCT_BAUD_9600;
   logic [7:0] tx_data_i = 8'h0;
   logic tx_valid_i = 1'b0;
   logic [3:0] cc_o;
   logic [31:0] enc_count_o;
   logic [7:0] rx_data_o;
   logic word_valid_o, overflow_o, enc_dir_o, enc_index_o, tx_ready_o, ser_tx_o;
   logic rx_valid_o, rx_frame_err_o;
   wire logic ser_rx_i;
   logic rx_brk = 1'b0;
   int failures = 0;
   int checked = 0;
   int ferr = 0;
   int rxv = 0;
   // Serial loopback, idle while in reset, pulled low for a line break
   assign ser_rx_i = (sys_rst_i | ser_tx_o) & !rx_brk;
   clct_top #(.DIV_9600(DIV)) u_dut (.clk_i, .sys_rst_i, .pix_clk_i, .pix_i, .cfg_mode_i,
      .word_o, .word_valid_o, .word_ready_i, .overflow_o, .overflow_clr_i, .cc_sel_i,
      .dig_out_i, .cc_o, .trig_start_i, .trig_on_index_i, .first_trig_cfg_i,
      .second_trig_cfg_i, .ext_trig_i, .enc_i, .enc_dir_o, .enc_count_o, .enc_index_o,
      .baud_sel_i, .tx_data_i, .tx_valid_i, .tx_ready_o, .ser_tx_o, .ser_rx_i, .rx_data_o,
      .rx_valid_o, .rx_frame_err_o);
   clct_cam_model u_cam (.pix_clk_o(pix_clk_i), .pix_o(pix_i));
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   // One-cycle receive pulses are counted as they stand
   always @(posedge clk_i) begin
      if (rx_frame_err_o === 1'b1) ferr++;
      if (rx_valid_o === 1'b1) rxv++;
   end
   // ==========================================================
   // Shared tasks
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic chk(input logic [64:0] got, input logic [64:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic pop(input logic [64:0] exp);
      int n;
      n = 0;
      while (word_valid_o !== 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      chk(word_o, exp);
      @(posedge clk_i) word_ready_i <= 1'b1;
      @(posedge clk_i) word_ready_i <= 1'b0;
      #1;
   endtask
   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      logic [9:0] fr;
      int n;
      int h;
      repeat (12) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      tick(1);
      foreach (ROWS[i]) begin
         @(posedge clk_i) begin
            cc_sel_i <= ROWS[i].sel;
            dig_out_i <= ROWS[i].dig;
            ext_trig_i <= ROWS[i].ext;
         end
         tick(5);
         chk(65'(cc_o), 65'(ROWS[i].exp));
      end
      // Reset in mid-run with lines driven high
      @(posedge clk_i) sys_rst_i <= 1'b1;
      tick(4);
      chk(65'({cc_o, overflow_o, word_valid_o, tx_ready_o, ser_tx_o, rx_valid_o, enc_count_o}),
         65'({4'h0, 5'b00110, 32'h0}));
      @(posedge clk_i) sys_rst_i <= 1'b0;
      @(posedge clk_i) cc_sel_i <= 4'h8;
      tick(3);
      for (int i = 0; i < 4; i++) begin
         h = cc_o[3];
         tick(1);
         chk(65'(cc_o[3]), 65'(!h[0]));
      end
      // Trigger delay and width, then a start during blank is refused
      @(posedge clk_i) cc_sel_i <= 4'h3;
      @(posedge clk_i) trig_start_i <= 2'b01;
      @(posedge clk_i) trig_start_i <= 2'b00;
      #1;
      n = 0;
      while (cc_o[0] !== 1'b1 && n < 50) begin
         tick(1);
         n++;
      end
      chk(65'(n), 65'h3);
      n = 0;
      while (cc_o[0] === 1'b1 && n < 50) begin
         tick(1);
         n++;
      end
      chk(65'(n), 65'h3);
      @(posedge clk_i) trig_start_i <= 2'b01;
      @(posedge clk_i) trig_start_i <= 2'b00;
      h = 0;
      repeat (20) begin
         tick(1);
         if (cc_o[0] !== 1'b0) h++;
      end
      chk(65'(h), 65'h0);
      foreach (SEQ[i]) begin
         @(posedge clk_i) enc_i <= {SEQ[i], 1'b0};
         tick(6);
         chk(65'({enc_dir_o, enc_count_o}), 65'({i < 4, 32'(i < 4 ? i + 1 : 7 - i)}));
      end
      @(posedge clk_i) begin
         trig_on_index_i <= 2'b10;
         enc_i.z <= 1'b1;
      end
      h = 0;
      repeat (15) begin
         tick(1);
         if (cc_o[1] !== 1'b0) h++;
      end
      chk(65'(h), 65'h1);
      for (int m = 0; m < 3; m++) begin
         @(posedge clk_i) cfg_mode_i <= clct_cfg_t'(m);
         u_cam.send({4'b1111, PAT});
         for (int q = 0; q < 3; q++) u_cam.send({4'b1111 ^ (4'b1000 >> q), ~PAT});
         pop({1'b1, PAT & MASK[m]});
         tick(10);
         chk(65'(word_valid_o), 65'h0);
      end
      // Seventeen words into a sixteen-word store with the reader stalled
      for (int i = 0; i < 17; i++) u_cam.send({4'b1110, 64'(i)});
      tick(8);
      chk(65'(overflow_o), 65'h1);
      for (int i = 0; i < 16; i++) pop({1'b0, 64'(i)});
      chk(65'(word_valid_o), 65'h0);
      @(posedge clk_i) overflow_clr_i <= 1'b1;
      @(posedge clk_i) overflow_clr_i <= 1'b0;
      tick(1);
      chk(65'(overflow_o), 65'h0);
      for (int b = 0; b < 5; b++) begin
         fr = {1'b1, 8'ha5 ^ 8'(b), 1'b0};
         @(posedge clk_i) begin
            baud_sel_i <= clct_baud_t'(b);
            tx_data_i <= fr[8:1];
            tx_valid_i <= 1'b1;
         end
         @(posedge clk_i) tx_valid_i <= 1'b0;
         #1;
         tick(DV[b] / 2);
         for (int j = 0; j < 10; j++) begin
            chk(65'(ser_tx_o), 65'(fr[j]));
            if (j < 9) tick(DV[b]);
         end
         n = 0;
         while (tx_ready_o !== 1'b1 && n < 3000) begin
            tick(1);
            n++;
         end
         chk(65'(n), 65'(DV[b] - DV[b] / 2));
         chk(65'(rx_data_o), 65'(fr[8:1]));
      end
      // Line low through the stop bit: one framing error, last byte kept
      @(posedge clk_i) begin
         baud_sel_i <= CLCT_BAUD_9600;
         rx_brk <= 1'b1;
      end
      tick(10 * DIV);
      @(posedge clk_i) rx_brk <= 1'b0;
      tick(3 * DIV);
      chk(65'(ferr), 65'h1);
      chk(65'(rxv), 65'h5);
      chk(65'(rx_data_o), 65'(fr[8:1]));
      finish_test();
   end
   // Longest rate frames dominate; about 55k cycles expected
   initial begin
      #1_600_000;
      failures++;
      finish_test();
   end
endmodule
